// *** rtl/pdmmic_pkg.sv ***
package pdmmic_pkg;
   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [11:0] OFF_TASK_START  = 12'h000;
   localparam logic [11:0] OFF_TASK_STOP   = 12'h004;
   localparam logic [11:0] OFF_EV_STARTED  = 12'h100;
   localparam logic [11:0] OFF_EV_STOPPED  = 12'h104;
   localparam logic [11:0] OFF_EV_END      = 12'h108;
   localparam logic [11:0] OFF_CLKCTRL     = 12'h504;
   localparam logic [11:0] OFF_MODE        = 12'h508;
   localparam logic [11:0] OFF_GAIN_L      = 12'h518;
   localparam logic [11:0] OFF_GAIN_R      = 12'h51C;
   localparam logic [11:0] OFF_RATIO       = 12'h520;
   localparam logic [11:0] OFF_PTR         = 12'h560;
   localparam logic [11:0] OFF_LEN         = 12'h564;
   localparam logic [11:0] OFF_STATUS      = 12'h600;
   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam int          MODE_MONO_BIT   = 0;
   localparam int          MODE_EDGE_BIT   = 1;
   localparam logic [7:0]  GAIN_DEFAULT    = 8'h28;
   localparam logic [7:0]  GAIN_LOWEST     = 8'h00;
   localparam logic [7:0]  GAIN_HIGHEST    = 8'h50;
   localparam logic [7:0]  CLKDIV_DEFAULT  = 8'h05;
   localparam int          GAIN_FRAC       = 5;
   localparam logic [6:0]  RATIO_64        = 7'h40;
   localparam logic [6:0]  RATIO_80        = 7'h50;
   localparam int          CIC_W           = 24;
   localparam int          SHIFT_64        = 2;
   localparam int          SHIFT_80        = 3;
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_RUN      = 2'b01,
      ST_STOPPING = 2'b10
   } pdmmic_state_t;
endpackage

// *** rtl/pdmmic_chan.sv ***
`timescale 1ns/1ps
// per-channel decimator: boxcar count over ratio bits, then gain
module pdmmic_chan (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clr_in,
   input  wire logic        bit_vld_in,
   input  wire logic        bit_in,
   input  wire logic        ratio80_in,
   input  wire logic [7:0]  gain_in,
   output logic             smp_vld_out,
   output logic [15:0]      smp_out
);
   logic [6:0]  cnt_reg,  cnt_next;
   logic [6:0]  ones_reg, ones_next;
   logic [15:0] smp_reg,  smp_next;
   logic        vld_reg,  vld_next;
   logic [6:0]  last;
   logic signed [9:0]  centred;
   logic signed [15:0] pcm;
   logic signed [24:0] scaled;
   logic signed [8:0]  gmul;

   always_comb begin
      last      = ratio80_in ? (pdmmic_pkg::RATIO_80 - 7'h01) : (pdmmic_pkg::RATIO_64 - 7'h01);
      cnt_next  = cnt_reg;
      ones_next = ones_reg;
      smp_next  = smp_reg;
      vld_next  = 1'b0;
      // centre the count and scale toward full 16-bit range
      centred   = 10'(2 * {3'b000, ones_reg + {6'h00, bit_in}}) - 10'(last + 7'h01);
      pcm       = ratio80_in ? 16'(centred * 16'sd409) : 16'(centred * 16'sd511);
      gmul      = $signed({1'b0, gain_in});
      scaled    = 25'(pcm * gmul) >>> pdmmic_pkg::GAIN_FRAC;
      if (bit_vld_in) begin
         if (cnt_reg == last) begin
            cnt_next  = 7'h00;
            ones_next = 7'h00;
            vld_next  = 1'b1;
            // saturate after gain
            if (scaled > 25'sd32767)        smp_next = 16'h7FFF;
            else if (scaled < -25'sd32768)  smp_next = 16'h8000;
            else                            smp_next = scaled[15:0];
         end else begin
            cnt_next  = cnt_reg + 7'h01;
            ones_next = ones_reg + {6'h00, bit_in};
         end
      end
      if (clr_in) begin
         cnt_next  = 7'h00;
         ones_next = 7'h00;
         vld_next  = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cnt_reg  <= 7'h00;
         ones_reg <= 7'h00;
         smp_reg  <= 16'h0000;
         vld_reg  <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         ones_reg <= ones_next;
         smp_reg  <= smp_next;
         vld_reg  <= vld_next;
      end
   end

   assign smp_vld_out = vld_reg;
   assign smp_out     = smp_reg;
endmodule

// *** rtl/pdmmic_top.sv ***
// Function
// - device drives the microphone bit clock, takes one or two data channels
// - two microphones share one data line, one clock phase each
// - default: left captured on falling edge, right on rising edge
// - edge swap: left on rising edge, right on falling edge
// - each channel decimated into 16-bit signed PCM
// - decimation ratio selectable 64 or 80
// - nominal output 16 kHz, 16-bit samples
// - bit clock frequency set by frequency field of clock control
// - stereo stores left/right alternately; mono stores left only
// - samples written to RAM by own DMA master
// - start task begins acquisition; stop task requests end
// - stop acts after current frame; then stopped event raised
// - per-channel gain stage, -20 dB to +20 dB around default; code multiplies linearly by gain/32, so 0x00 mutes and 0x50 gives 2.5x
// - separate left/right gain registers, 0.5 dB steps; code uses linear steps of 1/32
// - 32-bit word holds two samples, earlier/left in low half
// - buffer length counts 16-bit samples
// - buffer full raises end, continues with next pointer, raises started
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module pdmmic_top (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // microphones
   output logic             microphone_bit_clock_out,
   input  wire logic        pdm_data_in,
   // dma write master
   output logic             dma_req_out,
   output logic [31:0]      dma_addr_out,
   output logic [31:0]      dma_data_out,
   input  wire logic        dma_ack_in
);
   // ************************************************************
   // registers
   // ************************************************************
   pdmmic_pkg::pdmmic_state_t st_reg, st_next;
   logic [7:0]  clkdiv_reg, clkdiv_next;
   logic        mono_reg, mono_next;
   logic        edge_reg, edge_next;
   logic        ratio_reg, ratio_next;
   logic [7:0]  gain_l_reg, gain_l_next;
   logic [7:0]  gain_r_reg, gain_r_next;
   logic [31:0] ptr_reg, ptr_next;
   logic [14:0] len_reg, len_next;
   logic        ev_started_reg, ev_started_next;
   logic        ev_stopped_reg, ev_stopped_next;
   logic        ev_end_reg, ev_end_next;
   logic [31:0] prdata_reg, prdata_next;
   logic [31:0] base_reg, base_next;
   logic [14:0] cnt_reg, cnt_next;
   logic [31:0] word_reg, word_next;
   logic        half_reg, half_next;
   logic [15:0] hold_r_reg, hold_r_next;
   logic        req_reg, req_next;
   logic [31:0] addr_reg, addr_next;
   logic [31:0] data_reg, data_next;
   logic [7:0]  div_reg, div_next;
   logic        bclk_reg, bclk_next;
   logic        din_s1_reg, din_s2_reg;
   logic        wr_en, rd_en, start_t, stop_t, stop_pend_reg, stop_pend_next;
   logic        rise_bit, fall_bit, left_vld, right_vld, left_bit, right_bit;
   logic        vld_l, vld_r, clr_ch;
   logic [15:0] smp_l, smp_r;
   logic        mapped;

   // ************************************************************
   // apb decode
   // ************************************************************
   assign wr_en       = psel_in & penable_in & pwrite_in;
   assign rd_en       = psel_in & ~penable_in & ~pwrite_in;
   assign pready_out  = 1'b1;
   assign prdata_out  = prdata_reg;
   assign start_t     = wr_en && paddr_in == pdmmic_pkg::OFF_TASK_START && pwdata_in[0];
   assign stop_t      = wr_en && paddr_in == pdmmic_pkg::OFF_TASK_STOP && pwdata_in[0];

   always_comb begin
      mapped = 1'b1;
      case (paddr_in)
         pdmmic_pkg::OFF_TASK_START: prdata_next = 32'h0000_0000;
         pdmmic_pkg::OFF_TASK_STOP:  prdata_next = 32'h0000_0000;
         pdmmic_pkg::OFF_EV_STARTED: prdata_next = {31'h0, ev_started_reg};
         pdmmic_pkg::OFF_EV_STOPPED: prdata_next = {31'h0, ev_stopped_reg};
         pdmmic_pkg::OFF_EV_END:     prdata_next = {31'h0, ev_end_reg};
         pdmmic_pkg::OFF_CLKCTRL:    prdata_next = {24'h0, clkdiv_reg};
         pdmmic_pkg::OFF_MODE:       prdata_next = {30'h0, edge_reg, mono_reg};
         pdmmic_pkg::OFF_GAIN_L:     prdata_next = {24'h0, gain_l_reg};
         pdmmic_pkg::OFF_GAIN_R:     prdata_next = {24'h0, gain_r_reg};
         pdmmic_pkg::OFF_RATIO:      prdata_next = {31'h0, ratio_reg};
         pdmmic_pkg::OFF_PTR:        prdata_next = ptr_reg;
         pdmmic_pkg::OFF_LEN:        prdata_next = {17'h0, len_reg};
         pdmmic_pkg::OFF_STATUS:     prdata_next = {15'h0, cnt_reg, st_reg};
         default: begin
            prdata_next = 32'h0000_0000;
            mapped      = 1'b0;
         end
      endcase
      if (!rd_en) prdata_next = prdata_reg;
   end
   assign pslverr_out = psel_in & penable_in & ~mapped;

   // ************************************************************
   // bit clock and data sampling
   // ************************************************************
   always_comb begin
      div_next  = div_reg;
      bclk_next = bclk_reg;
      // idle: finish a high phase so the mics never see a runt pulse
      if (st_reg == pdmmic_pkg::ST_IDLE && !bclk_reg) begin
         div_next  = 8'h00;
         bclk_next = 1'b0;
      end else if (div_reg >= clkdiv_reg) begin
         div_next  = 8'h00;
         bclk_next = ~bclk_reg;
      end else begin
         div_next  = div_reg + 8'h01;
      end
   end
   assign microphone_bit_clock_out = bclk_reg;

   // sample just before each toggle: data has had a half period less the two synchroniser clocks to settle
   assign rise_bit  = (st_reg != pdmmic_pkg::ST_IDLE) && div_reg >= clkdiv_reg && !bclk_reg;
   assign fall_bit  = (st_reg != pdmmic_pkg::ST_IDLE) && div_reg >= clkdiv_reg && bclk_reg;
   assign left_vld  = edge_reg ? rise_bit : fall_bit;
   assign right_vld = edge_reg ? fall_bit : rise_bit;
   assign left_bit  = din_s2_reg;
   assign right_bit = din_s2_reg;
   assign clr_ch    = st_reg == pdmmic_pkg::ST_IDLE;

   pdmmic_chan u_left (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .clr_in      (clr_ch),
      .bit_vld_in  (left_vld),
      .bit_in      (left_bit),
      .ratio80_in  (ratio_reg),
      .gain_in     (gain_l_reg),
      .smp_vld_out (vld_l),
      .smp_out     (smp_l)
   );
   pdmmic_chan u_right (
      .mclk_in     (mclk_in),
      .rst_n_in    (rst_n_in),
      .clr_in      (clr_ch),
      .bit_vld_in  (right_vld),
      .bit_in      (right_bit),
      .ratio80_in  (ratio_reg),
      .gain_in     (gain_r_reg),
      .smp_vld_out (vld_r),
      .smp_out     (smp_r)
   );

   // ************************************************************
   // control, packing and dma
   // ************************************************************
   always_comb begin
      st_next         = st_reg;
      clkdiv_next     = clkdiv_reg;
      mono_next       = mono_reg;
      edge_next       = edge_reg;
      ratio_next      = ratio_reg;
      gain_l_next     = gain_l_reg;
      gain_r_next     = gain_r_reg;
      ptr_next        = ptr_reg;
      len_next        = len_reg;
      ev_started_next = ev_started_reg;
      ev_stopped_next = ev_stopped_reg;
      ev_end_next     = ev_end_reg;
      base_next       = base_reg;
      cnt_next        = cnt_reg;
      word_next       = word_reg;
      half_next       = half_reg;
      hold_r_next     = hold_r_reg;
      req_next        = req_reg;
      addr_next       = addr_reg;
      data_next       = data_reg;
      stop_pend_next  = stop_pend_reg | stop_t;
      // software clears, hardware sets afterwards so a set wins
      if (wr_en) begin
         case (paddr_in)
            pdmmic_pkg::OFF_EV_STARTED: ev_started_next = pwdata_in[0];
            pdmmic_pkg::OFF_EV_STOPPED: ev_stopped_next = pwdata_in[0];
            pdmmic_pkg::OFF_EV_END:     ev_end_next     = pwdata_in[0];
            pdmmic_pkg::OFF_CLKCTRL:    clkdiv_next     = pwdata_in[7:0];
            pdmmic_pkg::OFF_MODE: begin
               mono_next = pwdata_in[pdmmic_pkg::MODE_MONO_BIT];
               edge_next = pwdata_in[pdmmic_pkg::MODE_EDGE_BIT];
            end
            pdmmic_pkg::OFF_GAIN_L:     gain_l_next     = pwdata_in[7:0];
            pdmmic_pkg::OFF_GAIN_R:     gain_r_next     = pwdata_in[7:0];
            pdmmic_pkg::OFF_RATIO:      ratio_next      = pwdata_in[0];
            pdmmic_pkg::OFF_PTR:        ptr_next        = pwdata_in;
            pdmmic_pkg::OFF_LEN:        len_next        = pwdata_in[14:0];
            default: ;
         endcase
      end
      if (req_reg && dma_ack_in) req_next = 1'b0;
      case (st_reg)
         pdmmic_pkg::ST_IDLE: begin
            stop_pend_next = 1'b0;
            if (start_t) begin
               st_next         = pdmmic_pkg::ST_RUN;
               base_next       = ptr_reg;
               cnt_next        = 15'h0000;
               half_next       = 1'b0;
               ev_started_next = 1'b1;
            end
         end
         pdmmic_pkg::ST_RUN, pdmmic_pkg::ST_STOPPING: begin
            if (stop_pend_reg) st_next = pdmmic_pkg::ST_STOPPING;
            // right sample parked until its left partner is stored
            if (vld_r && !mono_reg) begin
               hold_r_next = smp_r;
            end
            if (vld_l && !req_reg) begin
               if (!mono_reg) begin
                  data_next   = {(vld_r ? smp_r : hold_r_reg), smp_l};
                  req_next    = 1'b1;
                  addr_next   = base_reg + {16'h0, cnt_reg, 1'b0};
                  cnt_next    = cnt_reg + 15'h0002;
               end else if (!half_reg) begin
                  word_next = {16'h0000, smp_l};
                  half_next = 1'b1;
               end else begin
                  data_next = {smp_l, word_reg[15:0]};
                  half_next = 1'b0;
                  req_next  = 1'b1;
                  addr_next = base_reg + {16'h0, cnt_reg, 1'b0};
                  cnt_next  = cnt_reg + 15'h0002;
               end
            end
            // frame boundary: one full buffer written and acknowledged
            if (!req_next && cnt_reg != 15'h0000 && cnt_reg >= len_reg) begin
               ev_end_next = 1'b1;
               cnt_next    = 15'h0000;
               if (st_reg == pdmmic_pkg::ST_STOPPING || stop_pend_reg) begin
                  st_next         = pdmmic_pkg::ST_IDLE;
                  ev_stopped_next = 1'b1;
               end else begin
                  base_next       = ptr_reg;
                  ev_started_next = 1'b1;
               end
            end
         end
         default: st_next = pdmmic_pkg::ST_IDLE;
      endcase
   end
   assign dma_req_out  = req_reg;
   assign dma_addr_out = addr_reg;
   assign dma_data_out = data_reg;

   always_ff @(posedge mclk_in) begin
      // pin synchroniser
      din_s1_reg <= pdm_data_in;
      din_s2_reg <= din_s1_reg;
      if (!rst_n_in) begin
         st_reg         <= pdmmic_pkg::ST_IDLE;
         clkdiv_reg     <= pdmmic_pkg::CLKDIV_DEFAULT;
         mono_reg       <= 1'b0;
         edge_reg       <= 1'b0;
         ratio_reg      <= 1'b0;
         gain_l_reg     <= pdmmic_pkg::GAIN_DEFAULT;
         gain_r_reg     <= pdmmic_pkg::GAIN_DEFAULT;
         ptr_reg        <= 32'h0000_0000;
         len_reg        <= 15'h0000;
         ev_started_reg <= 1'b0;
         ev_stopped_reg <= 1'b0;
         ev_end_reg     <= 1'b0;
         prdata_reg     <= 32'h0000_0000;
         base_reg       <= 32'h0000_0000;
         cnt_reg        <= 15'h0000;
         word_reg       <= 32'h0000_0000;
         half_reg       <= 1'b0;
         hold_r_reg     <= 16'h0000;
         req_reg        <= 1'b0;
         addr_reg       <= 32'h0000_0000;
         data_reg       <= 32'h0000_0000;
         div_reg        <= 8'h00;
         bclk_reg       <= 1'b0;
         stop_pend_reg  <= 1'b0;
      end else begin
         st_reg         <= st_next;
         clkdiv_reg     <= clkdiv_next;
         mono_reg       <= mono_next;
         edge_reg       <= edge_next;
         ratio_reg      <= ratio_next;
         gain_l_reg     <= gain_l_next;
         gain_r_reg     <= gain_r_next;
         ptr_reg        <= ptr_next;
         len_reg        <= len_next;
         ev_started_reg <= ev_started_next;
         ev_stopped_reg <= ev_stopped_next;
         ev_end_reg     <= ev_end_next;
         prdata_reg     <= prdata_next;
         base_reg       <= base_next;
         cnt_reg        <= cnt_next;
         word_reg       <= word_next;
         half_reg       <= half_next;
         hold_r_reg     <= hold_r_next;
         req_reg        <= req_next;
         addr_reg       <= addr_next;
         data_reg       <= data_next;
         div_reg        <= div_next;
         bclk_reg       <= bclk_next;
         stop_pend_reg  <= stop_pend_next;
      end
   end
endmodule

// *** tb/pdmmic_top_chk.sv ***
`timescale 1ns/1ps
// ************************************************************
// port checker
// ************************************************************
module pdmmic_top_chk (
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic        microphone_bit_clock_out,
   input wire logic        dma_req_out,
   input wire logic [31:0] dma_addr_out,
   input wire logic [31:0] dma_data_out,
   input wire logic        dma_ack_in
);
   logic        wr_hit, go_hit;
   logic [7:0]  div_reg, div_next, hold_reg, hold_next;
   logic [15:0] gap_reg, gap_next;
   logic        run_reg, run_next, seen_reg, seen_next, bclk_reg, req_reg;
   assign wr_hit = psel_in && penable_in && pwrite_in;
   assign go_hit = wr_hit && paddr_in == pdmmic_pkg::OFF_TASK_START && pwdata_in[0];
   always_comb begin
      div_next = div_reg;
      if (wr_hit && paddr_in == pdmmic_pkg::OFF_CLKCTRL) div_next = pwdata_in[7:0];
      run_next = run_reg || go_hit;
      seen_next = seen_reg || (dma_req_out && !req_reg);
      // saturate: a long idle never wraps
      hold_next = (microphone_bit_clock_out != bclk_reg) ? 8'h00 :
                  hold_reg + {7'h00, hold_reg != 8'hFF};
      gap_next = (dma_req_out && !req_reg) ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hFFFF};
   end
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         div_reg  <= pdmmic_pkg::CLKDIV_DEFAULT;
         run_reg  <= 1'h0;
         seen_reg <= 1'h0;
         hold_reg <= 8'hFF;
         gap_reg  <= 16'h0000;
         bclk_reg <= 1'h0;
         req_reg  <= 1'h0;
      end else begin
         div_reg  <= div_next;
         run_reg  <= run_next;
         seen_reg <= seen_next;
         hold_reg <= hold_next;
         gap_reg  <= gap_next;
         bclk_reg <= microphone_bit_clock_out;
         req_reg  <= dma_req_out;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_addr_hold;
      dma_req_out && !dma_ack_in |=> dma_req_out && $stable(dma_addr_out);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("dma address moved");
   property p_data_hold;
      dma_req_out && !dma_ack_in |=> $stable(dma_data_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("dma data moved");
   property p_req_drop;
      dma_req_out && dma_ack_in |=> !dma_req_out;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
   property p_align;
      dma_req_out |-> dma_addr_out[1:0] == 2'h0;
   endproperty
   a_align: assert property (p_align) else $error("unaligned word");
   property p_half;
      $fell(microphone_bit_clock_out) |-> hold_reg == div_reg;
   endproperty
   a_half: assert property (p_half) else $error("bit clock high time wrong");
   property p_start_clk;
      go_hit |-> ##[1:40] microphone_bit_clock_out;
   endproperty
   a_start_clk: assert property (p_start_clk) else $error("no bit clock after start");
   property p_gap;
      $rose(dma_req_out) && seen_reg |-> int'(gap_reg) >= 128 * (int'(div_reg) + 1) - 1;
   endproperty
   a_gap: assert property (p_gap) else $error("words too close");
   property p_idle;
      !run_reg |-> !microphone_bit_clock_out && !dma_req_out;
   endproperty
   a_idle: assert property (p_idle) else $error("activity before start");
   c_word: cover property (dma_req_out && dma_ack_in);
   c_fall: cover property ($fell(microphone_bit_clock_out));
   c_next: cover property ($rose(dma_req_out) && seen_reg);
endmodule
bind pdmmic_top pdmmic_top_chk pdmmic_top_chk_i (.mclk_in, .rst_n_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pwdata_in, .microphone_bit_clock_out, .dma_req_out,
   .dma_addr_out, .dma_data_out, .dma_ack_in);

// *** tb/pdmmic_mic_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// two microphones on one data line
// ************************************************************
module pdmmic_mic_model #(
   parameter realtime DRIVE_NS = 5.0
) (
   input  wire logic bit_clk_in,
   input  wire logic left_val_in,
   input  wire logic right_val_in,
   output logic      data_out
);
   realtime last_edge = 0.0;
   initial data_out = 1'h0;
   always @(posedge bit_clk_in) begin
      last_edge = $realtime;
      #(DRIVE_NS) data_out = left_val_in;
   end
   always @(negedge bit_clk_in) begin
      last_edge = $realtime;
      #(DRIVE_NS) data_out = right_val_in;
   end
   // clock stopped: no mic holds the line, so it wanders
   always #35 if ($realtime - last_edge > 300.0) data_out = ~data_out;
endmodule

// *** tb/test_pdm_microphone_interface.sv ***
`timescale 1ns/1ps
module test_pdm_microphone_interface;
   logic        mclk_in, rst_n_in, psel_in, penable_in, pwrite_in, pdm_data_in, dma_ack_in = 1'h0;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, dma_addr_out, dma_data_out, rd, q_addr[$], q_data[$];
   logic        pready_out, pslverr_out, microphone_bit_clock_out, dma_req_out, err;
   logic        left_val, right_val;
   int          q_cyc[$], error_cnt = 0, num_checks = 0, cyc = 0, wt = 0, stall = 0;
   realtime     brise = 0.0, bper = 0.0;
   pdmmic_top pdmmic_top_i (.mclk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .microphone_bit_clock_out,
      .pdm_data_in, .dma_req_out, .dma_addr_out, .dma_data_out, .dma_ack_in);
   pdmmic_mic_model pdmmic_mic_model_i (.bit_clk_in(microphone_bit_clock_out),
      .left_val_in(left_val), .right_val_in(right_val), .data_out(pdm_data_in));
   initial begin
      mclk_in = 1'h0;
      forever #5 mclk_in = ~mclk_in;
   end
   always @(posedge microphone_bit_clock_out) begin
      bper = $realtime - brise;
      brise = $realtime;
   end
   // ************************************************************
   // ram side: acks after a stall, one word outstanding
   // ************************************************************
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      dma_ack_in <= 1'h0;
      if (dma_req_out === 1'h1 && dma_ack_in !== 1'h1) begin
         if (wt >= stall) begin
            dma_ack_in <= 1'h1;
            q_addr.push_back(dma_addr_out);
            q_data.push_back(dma_data_out);
            q_cyc.push_back(cyc);
            wt <= 0;
         end else wt <= wt + 1;
      end
   end
   task automatic give_verdict();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic timeout();
      chk("wait", 32'h0, 32'h1);
      give_verdict();
   endtask
   function automatic logic [31:0] pos(input logic [15:0] s);
      return {31'h0, s[15] === 1'h0 && s !== 16'h0000};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_in);
      psel_in   <= 1'h1;
      pwrite_in <= w;
      paddr_in  <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         n++;
      end while (pready_out !== 1'h1 && n < 20);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
      if (n >= 20) timeout();
   endtask
   // ************************************************************
   // one run: program, start, take nw words, stop, await stopped
   // ************************************************************
   task automatic acquire(input logic [31:0] mode, ratio, gl, gr, input int nw);
      int k;
      q_addr.delete();
      q_data.delete();
      q_cyc.delete();
      apb(1'h1, pdmmic_pkg::OFF_MODE, mode);
      apb(1'h1, pdmmic_pkg::OFF_RATIO, ratio);
      apb(1'h1, pdmmic_pkg::OFF_GAIN_L, gl);
      apb(1'h1, pdmmic_pkg::OFF_GAIN_R, gr);
      apb(1'h1, pdmmic_pkg::OFF_PTR, 32'h0000_1000);
      apb(1'h1, pdmmic_pkg::OFF_LEN, 32'h4);
      apb(1'h1, pdmmic_pkg::OFF_TASK_START, 32'h1);
      apb(1'h1, pdmmic_pkg::OFF_PTR, 32'h0000_2000);
      for (k = 0; k < 30000 && q_data.size() < nw; k++) @(posedge mclk_in);
      if (k >= 30000) timeout();
      apb(1'h1, pdmmic_pkg::OFF_TASK_STOP, 32'h1);
      k = 0;
      do begin
         apb(1'h0, pdmmic_pkg::OFF_EV_STOPPED, 32'h0);
         k++;
      end while (rd[0] !== 1'h1 && k < 3000);
      if (k >= 3000) timeout();
      chk("frame words", 32'h0, q_data.size() % 2);
      apb(1'h0, pdmmic_pkg::OFF_EV_END, 32'h0);
      chk("end event", 32'h1, rd);
      apb(1'h0, pdmmic_pkg::OFF_EV_STARTED, 32'h0);
      chk("started event", 32'h1, rd);
      chk("idle", 32'h0, {30'h0, microphone_bit_clock_out, dma_req_out});
      chk("addr0", 32'h1000, q_addr[0]);
      chk("addr1", 32'h1004, q_addr[1]);
      chk("addr2", 32'h2000, q_addr[2]);
      apb(1'h1, pdmmic_pkg::OFF_EV_STARTED, 32'h0);
      apb(1'h1, pdmmic_pkg::OFF_EV_STOPPED, 32'h0);
      apb(1'h1, pdmmic_pkg::OFF_EV_END, 32'h0);
   endtask
   task automatic t_reset();
      apb(1'h0, pdmmic_pkg::OFF_GAIN_L, 32'h0);
      chk("gain left", pdmmic_pkg::GAIN_DEFAULT, rd);
      apb(1'h0, pdmmic_pkg::OFF_CLKCTRL, 32'h0);
      chk("divider", pdmmic_pkg::CLKDIV_DEFAULT, rd);
      apb(1'h0, 12'h050, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
   endtask
   task automatic t_stereo();
      apb(1'h1, pdmmic_pkg::OFF_CLKCTRL, 32'h2);
      stall = 3;
      acquire(32'h0, 32'h0, pdmmic_pkg::GAIN_DEFAULT, pdmmic_pkg::GAIN_DEFAULT, 3);
      chk("left", 32'h1, pos(q_data[1][15:0]));
      chk("right", 32'h1, {31'h0, q_data[1][31]});
      chk("gap", 2 * 3 * 64, q_cyc[2] - q_cyc[1]);
      chk("bit period", 32'd60, int'(bper));
   endtask
   task automatic t_swap80();
      stall = 0;
      acquire(32'h2, 32'h1, pdmmic_pkg::GAIN_DEFAULT, pdmmic_pkg::GAIN_DEFAULT, 3);
      chk("swap left", 32'h1, {31'h0, q_data[1][15]});
      chk("swap right", 32'h1, pos(q_data[1][31:16]));
      chk("gap80", 2 * 3 * 80, q_cyc[2] - q_cyc[1]);
   endtask
   task automatic t_mono();
      acquire(32'h1, 32'h0, pdmmic_pkg::GAIN_DEFAULT, pdmmic_pkg::GAIN_DEFAULT, 3);
      chk("mono low", 32'h1, pos(q_data[1][15:0]));
      chk("mono high", 32'h1, pos(q_data[1][31:16]));
      chk("mono gap", 2 * 2 * 3 * 64, q_cyc[2] - q_cyc[1]);
   endtask
   task automatic t_gain();
      stall = 2;
      acquire(32'h0, 32'h0, pdmmic_pkg::GAIN_LOWEST, pdmmic_pkg::GAIN_HIGHEST, 3);
      chk("left muted", 32'h0, {16'h0, q_data[1][15:0]});
      chk("right kept", 32'h1, {31'h0, q_data[1][31]});
   endtask
   initial begin
      rst_n_in = 1'h0;
      psel_in = 1'h0;
      penable_in = 1'h0;
      pwrite_in = 1'h0;
      paddr_in = 12'h000;
      pwdata_in = 32'h0;
      left_val = 1'h1;
      right_val = 1'h0;
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      t_reset();
      t_stereo();
      t_swap80();
      t_mono();
      t_gain();
      give_verdict();
   end
endmodule
